/* design/sbcg_consts.svh */
// constants of the serial baud clock generator
`ifndef SBCG_CONSTS_SVH
`define SBCG_CONSTS_SVH

`define SBCG_ADDR_W       8
`define SBCG_OFS_CFG      8'h08
`define SBCG_OFS_STAT     8'h0c
`define SBCG_CFG_RST      32'h00003c00
`define SBCG_CLOCK_DIVIDER_RATIO_HI    25
`define SBCG_CLOCK_DIVIDER_RATIO_LO    16
`define SBCG_SAMPLE_COUNT_DENOMINATOR_HI     14
`define SBCG_SAMPLE_COUNT_DENOMINATOR_LO     10
`define SBCG_SAMPLE_COUNT_PREDIVIDER_HI    9
`define SBCG_SAMPLE_COUNT_PREDIVIDER_LO    8
`define SBCG_TMSRC_BIT    5
`define SBCG_TMEN_BIT     4
`define SBCG_SPSEL_HI     3
`define SBCG_SPSEL_LO     2
`define SBCG_PTSEL_BIT    1
`define SBCG_RSEL_BIT     0
`define SBCG_STAT_BUSY    10
`define SBCG_FUNC_UART    3'h2
`define SBCG_ABD_FALLS    3'h4
`define SBCG_ABD_BITS     13'h0006
`define SBCG_ABD_CNT_W    13

`endif

/* design/sbcg_pkg.sv */
// types of the serial baud clock generator
package sbcg_pkg;

    typedef enum logic [1:0] {
        SBCG_SP_DIV,
        SBCG_SP_PROT,
        SBCG_SP_SCLK,
        SBCG_SP_REF
    } sbcg_samp_src_t;

    typedef enum logic {
        SBCG_ABD_IDLE,
        SBCG_ABD_MEAS
    } sbcg_abd_st_t;

    typedef struct packed {
        logic [9:0]     clock_divider_ratio;
        logic [4:0]     sample_count_denominator;
        logic [1:0]     sample_count_predivider;
        logic           tmsrc;
        logic           tmen;
        sbcg_samp_src_t spsel;
        logic           ptsel;
        logic           rsel;
        logic           half;
        logic           sclk_prev;
        logic           rx_prev;
        logic [9:0]     tcnt;
        logic [31:0]    rdata;
    } sbcg_top_state_t;

    typedef struct packed {
        sbcg_abd_st_t   st;
        logic [2:0]     falls;
        logic [12:0]    cnt;
        logic           upd;
        logic [9:0]     val;
    } sbcg_abd_state_t;

endpackage

/* design/sbcg_abd_if.sv */
// link between the generator core and its auto-baud measurement
`timescale 1ns/100ps
`default_nettype none
interface sbcg_abd_if;
    logic       prot_tick;
    logic       rx_fall;
    logic       arm;
    logic       upd_valid;
    logic [9:0] upd_value;
    logic       busy;

    modport ctrl (output prot_tick, output rx_fall, output arm,
                  input upd_valid, input upd_value, input busy);
    modport meas (input prot_tick, input rx_fall, input arm,
                  output upd_valid, output upd_value, output busy);
endinterface
`default_nettype wire

/* design/sbcg_div_stage.sv */
// one programmable divide-by-(ratio+1) stage on a tick stream
`timescale 1ns/100ps
`default_nettype none
module sbcg_div_stage #(
    parameter int W = 10
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    // tick stream
    input  wire logic         in_tick,
    input  wire logic [W-1:0] ratio,
    output logic              out_tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } sbcg_div_state_t;

    sbcg_div_state_t s_q;
    sbcg_div_state_t s_d;
    logic            wrap;

    // compare with >= so a shrinking ratio never strands the counter
    assign wrap     = (s_q.cnt >= ratio);
    assign out_tick = in_tick && wrap;

    always_comb begin
        s_d = s_q;
        if (in_tick) begin
            s_d.cnt = wrap ? '0 : s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

/* design/sbcg_auto_baud.sv */
// auto-baud measurement over a received 0x55 pattern
`timescale 1ns/100ps
`default_nettype none
`include "sbcg_consts.svh"
module sbcg_auto_baud (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // core link
    sbcg_abd_if.meas  abd
);
    sbcg_pkg::sbcg_abd_state_t s_q;
    sbcg_pkg::sbcg_abd_state_t s_d;
    logic [12:0]               avg;

    // six bit times lie between the first and the fourth falling edge
    // include the tick of the closing cycle, else the count is one tick short
    assign avg = ((s_q.cnt == '1) ? s_q.cnt : s_q.cnt + 13'(abd.prot_tick)) / `SBCG_ABD_BITS;

    assign abd.upd_valid = s_q.upd;
    assign abd.upd_value = s_q.val;
    assign abd.busy      = (s_q.st == sbcg_pkg::SBCG_ABD_MEAS);

    always_comb begin
        s_d     = s_q;
        s_d.upd = 1'b0;
        case (s_q.st)
            sbcg_pkg::SBCG_ABD_IDLE: begin
                if (abd.arm && abd.rx_fall) begin
                    s_d.st    = sbcg_pkg::SBCG_ABD_MEAS;
                    s_d.falls = 3'h1;
                    s_d.cnt   = '0;
                end
            end
            sbcg_pkg::SBCG_ABD_MEAS: begin
                if (abd.prot_tick && s_q.cnt != '1) begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
                if (!abd.arm) begin
                    s_d.st = sbcg_pkg::SBCG_ABD_IDLE;
                end else if (abd.rx_fall) begin
                    s_d.falls = s_q.falls + 1'b1;
                    if (s_d.falls == `SBCG_ABD_FALLS) begin
                        s_d.st  = sbcg_pkg::SBCG_ABD_IDLE;
                        s_d.upd = 1'b1;
                        s_d.val = (avg > 13'h03ff) ? 10'h3ff : avg[9:0];
                    end
                end
            end
            default: begin
                s_d.st = sbcg_pkg::SBCG_ABD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '{st: sbcg_pkg::SBCG_ABD_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

/* design/sbcg_top.sv */
// baud rate and sample clock generator with its configuration register
`timescale 1ns/100ps
`default_nettype none
`include "sbcg_consts.svh"
module sbcg_top (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // register port
    input  wire logic [`SBCG_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rdata,
    // controller context
    input  wire logic [2:0]              function_select,
    input  wire logic                    auto_baud_enable,
    input  wire logic                    rx_in,
    input  wire logic                    sclk_in,
    // generated tick streams
    output logic                         prot_tick,
    output logic                         div_tick,
    output logic                         samp_tick,
    output logic                         sample_tick,
    // timing counter and measurement status
    output logic      [9:0]              timing_count,
    output logic                         baud_detect_busy
);
    sbcg_pkg::sbcg_top_state_t s_q;
    sbcg_pkg::sbcg_top_state_t s_d;
    sbcg_abd_if                abd ();

    logic ref_tick;
    logic sclk_tick;
    logic pds_tick;
    logic tm_tick;
    logic uart_mode;
    logic wr_cfg;
    logic [31:0] cfg_img;

    // only the peripheral clock exists, reserved code falls back to it
    assign ref_tick  = 1'b1;
    // half rate by a free toggle
    assign prot_tick = s_q.ptsel ? s_q.half : ref_tick;
    assign sclk_tick = sclk_in && !s_q.sclk_prev;
    assign uart_mode = (function_select == `SBCG_FUNC_UART);
    assign wr_cfg    = reg_wr && (reg_addr == `SBCG_OFS_CFG);

    sbcg_div_stage #(.W(10)) u_clock_divider_ratio (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .in_tick  (prot_tick),
        .ratio    (s_q.clock_divider_ratio),
        .out_tick (div_tick)
    );

    always_comb begin
        case (s_q.spsel)
            sbcg_pkg::SBCG_SP_DIV:  samp_tick = div_tick;
            sbcg_pkg::SBCG_SP_PROT: samp_tick = prot_tick;
            sbcg_pkg::SBCG_SP_SCLK: samp_tick = sclk_tick;
            sbcg_pkg::SBCG_SP_REF:  samp_tick = ref_tick;
            default:                samp_tick = div_tick;
        endcase
    end

    sbcg_div_stage #(.W(2)) u_prediv (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .in_tick  (samp_tick),
        .ratio    (s_q.sample_count_predivider),
        .out_tick (pds_tick)
    );

    sbcg_div_stage #(.W(5)) u_denom (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .in_tick  (pds_tick),
        .ratio    (s_q.sample_count_denominator),
        .out_tick (sample_tick)
    );

    assign abd.prot_tick = prot_tick;
    assign abd.rx_fall   = s_q.rx_prev && !rx_in;
    // armed only with enable in UART mode
    assign abd.arm       = auto_baud_enable && uart_mode;

    sbcg_auto_baud u_abd (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .abd     (abd.meas)
    );

    assign tm_tick = s_q.tmsrc ? div_tick : prot_tick;

    always_comb begin
        cfg_img = '0;
        cfg_img[`SBCG_CLOCK_DIVIDER_RATIO_HI:`SBCG_CLOCK_DIVIDER_RATIO_LO] = s_q.clock_divider_ratio;
        cfg_img[`SBCG_SAMPLE_COUNT_DENOMINATOR_HI:`SBCG_SAMPLE_COUNT_DENOMINATOR_LO]   = s_q.sample_count_denominator;
        cfg_img[`SBCG_SAMPLE_COUNT_PREDIVIDER_HI:`SBCG_SAMPLE_COUNT_PREDIVIDER_LO] = s_q.sample_count_predivider;
        cfg_img[`SBCG_TMSRC_BIT]                 = s_q.tmsrc;
        cfg_img[`SBCG_TMEN_BIT]                  = s_q.tmen;
        cfg_img[`SBCG_SPSEL_HI:`SBCG_SPSEL_LO]   = s_q.spsel;
        cfg_img[`SBCG_PTSEL_BIT]                 = s_q.ptsel;
        cfg_img[`SBCG_RSEL_BIT]                  = s_q.rsel;
    end

    always_comb begin
        s_d           = s_q;
        s_d.half      = !s_q.half;
        s_d.sclk_prev = sclk_in;
        s_d.rx_prev   = rx_in;
        s_d.rdata     = '0;
        if (wr_cfg) begin
            s_d.clock_divider_ratio = reg_wdata[`SBCG_CLOCK_DIVIDER_RATIO_HI:`SBCG_CLOCK_DIVIDER_RATIO_LO];
            s_d.sample_count_denominator  = reg_wdata[`SBCG_SAMPLE_COUNT_DENOMINATOR_HI:`SBCG_SAMPLE_COUNT_DENOMINATOR_LO];
            s_d.sample_count_predivider = reg_wdata[`SBCG_SAMPLE_COUNT_PREDIVIDER_HI:`SBCG_SAMPLE_COUNT_PREDIVIDER_LO];
            s_d.tmsrc  = reg_wdata[`SBCG_TMSRC_BIT];
            s_d.tmen   = reg_wdata[`SBCG_TMEN_BIT];
            s_d.spsel  = sbcg_pkg::sbcg_samp_src_t'(reg_wdata[`SBCG_SPSEL_HI:`SBCG_SPSEL_LO]);
            s_d.ptsel  = reg_wdata[`SBCG_PTSEL_BIT];
            s_d.rsel   = reg_wdata[`SBCG_RSEL_BIT];
        end
        // hardware update beats a same-cycle software write
        if (abd.upd_valid) begin
            s_d.clock_divider_ratio = abd.upd_value;
        end
        if (!s_q.tmen) begin
            s_d.tcnt = '0;
        end else if (tm_tick) begin
            s_d.tcnt = s_q.tcnt + 1'b1;
        end
        // unmapped reads return zero
        if (reg_rd) begin
            case (reg_addr)
                `SBCG_OFS_CFG: begin
                    s_d.rdata = cfg_img;
                end
                `SBCG_OFS_STAT: begin
                    s_d.rdata[9:0]             = s_q.tcnt;
                    s_d.rdata[`SBCG_STAT_BUSY] = abd.busy;
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '{sample_count_denominator: 5'(`SBCG_CFG_RST >> `SBCG_SAMPLE_COUNT_DENOMINATOR_LO),
                     spsel: sbcg_pkg::SBCG_SP_DIV,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata        = s_q.rdata;
    assign timing_count     = s_q.tcnt;
    assign baud_detect_busy = abd.busy;
endmodule
`default_nettype wire

/* verif/sbcg_top_properties.sv */
// port properties of the baud clock generator
`timescale 1ns/100ps
`default_nettype none
module sbcg_top_properties (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    // controller context
    input wire logic [2:0] function_select,
    input wire logic       auto_baud_enable,
    input wire logic       rx_in,
    // generated streams
    input wire logic       prot_tick,
    input wire logic       div_tick,
    input wire logic       samp_tick,
    input wire logic       sample_tick,
    input wire logic [9:0] timing_count,
    input wire logic       baud_detect_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_div_on_prot; div_tick |-> prot_tick; endproperty
    a_div_on_prot: assert property (p_div_on_prot)
        else $error("divider tick without protocol tick");
    property p_samp_cnt; sample_tick |-> samp_tick; endproperty
    a_samp_cnt: assert property (p_samp_cnt)
        else $error("sample counter tick without sample clock tick");
    property p_prot_rate; !prot_tick |=> prot_tick; endproperty
    a_prot_rate: assert property (p_prot_rate)
        else $error("protocol tick slower than half rate");
    property p_tm_step;
        timing_count != $past(timing_count)
            |-> (timing_count == $past(timing_count) + 10'h1 || timing_count == 10'h0);
    endproperty
    a_tm_step: assert property (p_tm_step)
        else $error("timing counter jumped");
    // divider ticks only come with protocol ticks, so either source needs one
    property p_tm_src; timing_count == $past(timing_count) + 10'h1 |-> $past(prot_tick); endproperty
    a_tm_src: assert property (p_tm_src)
        else $error("timing counter advanced without a tick");
    property p_abd_start;
        $rose(baud_detect_busy) |-> !$past(rx_in) && $past(rx_in, 2);
    endproperty
    a_abd_start: assert property (p_abd_start)
        else $error("measurement started without a falling edge");
    property p_abd_arm;
        $rose(baud_detect_busy) |-> $past(function_select) == 3'h2 && $past(auto_baud_enable);
    endproperty
    a_abd_arm: assert property (p_abd_arm)
        else $error("measurement started outside uart auto-baud");
    property p_abd_abort;
        baud_detect_busy && (!auto_baud_enable || function_select != 3'h2) |=> !baud_detect_busy;
    endproperty
    a_abd_abort: assert property (p_abd_abort)
        else $error("measurement kept running after disarm");
endmodule

bind sbcg_top sbcg_top_properties sbcg_top_properties_i (.ref_clk, .sys_rst,
    .function_select, .auto_baud_enable, .rx_in, .prot_tick, .div_tick, .samp_tick,
    .sample_tick, .timing_count, .baud_detect_busy);
`default_nettype wire

/* verif/sbcg_top_tb_top.sv */
// self-checking bench of the baud clock generator
`timescale 1ns/100ps
`default_nettype none
module sbcg_top_tb_top;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [2:0]  function_select = 3'h0;
    logic        auto_baud_enable = 1'b0;
    logic        rx_in = 1'b1;
    logic        sclk_in = 1'b0;
    logic        prot_tick;
    logic        div_tick;
    logic        samp_tick;
    logic        sample_tick;
    logic [9:0]  timing_count;
    logic        baud_detect_busy;
    logic [2:0]  sclk_cnt = 3'h0;
    logic [31:0] rd_v;
    int          n_mismatch = 0;
    int          checked = 0;
    int          n_p, n_d, n_s, n_c, t0;

    sbcg_top sbcg_top_i (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .function_select, .auto_baud_enable, .rx_in, .sclk_in, .prot_tick,
        .div_tick, .samp_tick, .sample_tick, .timing_count, .baud_detect_busy);

    always #25 ref_clk = ~ref_clk;
    // serial clock rises once every 6 cycles
    always @(posedge ref_clk) begin
        sclk_cnt <= (sclk_cnt == 3'h2) ? 3'h0 : sclk_cnt + 3'h1;
        if (sclk_cnt == 3'h2)
            sclk_in <= ~sclk_in;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // tick phase is free-running, so counts may be one off
    task automatic near(input int got, input int exp);
        checked++;
        if (got > exp + 1 || got < exp - 1) begin
            n_mismatch++;
            $display("BAD t=%0t count %0d exp %0d", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rd_v = reg_rdata;
    endtask
    function automatic logic [31:0] cfg(input logic [9:0] cd, input logic [4:0] ds,
                                        input logic [1:0] pd, input logic [3:0] tsp,
                                        input logic pt);
        return {6'h0, cd, 1'b0, ds, pd, 2'h0, tsp, pt, 1'b0};
    endfunction
    task automatic count_ticks();
        n_p = 0;
        n_d = 0;
        n_s = 0;
        n_c = 0;
        repeat (240) begin
            @(negedge ref_clk);
            n_p += int'(prot_tick === 1'b1);
            n_d += int'(div_tick === 1'b1);
            n_s += int'(samp_tick === 1'b1);
            n_c += int'(sample_tick === 1'b1);
        end
    endtask
    task automatic send(input int b, input bit ab);
        logic [9:0] fr;
        fr = {1'b1, 8'h55, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            rx_in <= fr[i];
            if (ab && i == 3)
                function_select <= 3'h1;
            repeat (b - 1) @(posedge ref_clk);
            #1;
            if (i == 1)
                check({31'h0, baud_detect_busy}, 32'h1);
        end
        // fifth falling edge starts a stale measurement, drop the arm once
        @(posedge ref_clk);
        function_select <= 3'h2;
        auto_baud_enable <= 1'b0;
        @(posedge ref_clk);
        auto_baud_enable <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        rd(8'h08);
        check(rd_v, 32'h00003c00);
        rd(8'h0c);
        check(rd_v, 32'h0);
        count_ticks();
        near(n_p, 240);
        near(n_c, 15);
    endtask
    task automatic t_regs();
        wr(8'h08, 32'hffffffff);
        wr(8'h04, 32'h0);
        rd(8'h08);
        check(rd_v & 32'hfffffffe, 32'h03ff7f3e);
    endtask
    task automatic t_rates();
        logic [31:0] c [5];
        int          e [5][4];
        c = '{cfg(10'h3, 5'h2, 2'h1, 4'h0, 1'b1), cfg(10'h3, 5'h2, 2'h1, 4'h1, 1'b1),
              cfg(10'h3, 5'h3, 2'h0, 4'h2, 1'b1), cfg(10'h3, 5'h4, 2'h2, 4'h3, 1'b0),
              cfg(10'h3ff, 5'h0, 2'h0, 4'h0, 1'b0)};
        e = '{'{120, 30, 30, 5}, '{120, 30, 120, 20}, '{120, 30, 40, 10},
              '{240, 60, 240, 16}, '{240, 0, 0, 0}};
        for (int k = 0; k < 5; k++) begin
            wr(8'h08, c[k]);
            count_ticks();
            near(n_p, e[k][0]);
            near(n_d, e[k][1]);
            near(n_s, e[k][2]);
            near(n_c, e[k][3]);
        end
    endtask
    task automatic t_timer();
        wr(8'h08, cfg(10'h4, 5'hf, 2'h0, 4'h0, 1'b0));
        repeat (20) @(posedge ref_clk);
        #1;
        check({22'h0, timing_count}, 32'h0);
        wr(8'h08, cfg(10'h4, 5'hf, 2'h0, 4'h4, 1'b0));
        #1;
        t0 = int'(timing_count);
        repeat (100) @(negedge ref_clk);
        near(int'(timing_count) - t0, 100);
        wr(8'h08, cfg(10'h4, 5'hf, 2'h0, 4'hc, 1'b0));
        #1;
        t0 = int'(timing_count);
        repeat (100) @(negedge ref_clk);
        near(int'(timing_count) - t0, 20);
    endtask
    task automatic t_abd();
        wr(8'h08, cfg(10'h3ff, 5'hf, 2'h0, 4'h0, 1'b0));
        function_select <= 3'h2;
        auto_baud_enable <= 1'b1;
        send(8, 1'b0);
        rd(8'h08);
        check({22'h0, rd_v[25:16]}, 32'h8);
        send(10, 1'b0);
        rd(8'h08);
        check({22'h0, rd_v[25:16]}, 32'ha);
        send(12, 1'b1);
        rd(8'h08);
        check({22'h0, rd_v[25:16]}, 32'ha);
        check({31'h0, baud_detect_busy}, 32'h0);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_rates();
        t_timer();
        t_abd();
        give_verdict();
    end
    // whole run needs about 2000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
